/* rtl/acfr_consts.svh */
`ifndef ACFR_CONSTS_SVH
`define ACFR_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define ACFR_OFF_SELECT      12'h000
`define ACFR_OFF_RELAY_CFG   12'h004
`define ACFR_OFF_STATUS      12'h008
`define ACFR_OFF_TRIP_CLR    12'h00c
`define ACFR_SELECT_RESET    5'h0c
`define ACFR_RELAY_CFG_RESET 3'h2
`define ACFR_BIT_LV          0
`define ACFR_BIT_TRIP        1
`define ACFR_BIT_RETRY       2
`define ACFR_STATUS_AUX_BIT  3
// ****************************************
// selection codes
// ****************************************
`define ACFR_SEL_FREQ_ARRIVAL  5'h00
`define ACFR_SEL_MMC           5'h17
`define ACFR_SEL_LAST          5'h19
// ****************************************
// timing
// ****************************************
`define ACFR_CLOCK_HZ          40000000
`define ACFR_LOAD_36S_MS       36000
`define ACFR_LOAD_TRIP_MS      60000
`define ACFR_INTERLOCK_MS      50
`define ACFR_MS_CYCLES         ((`ACFR_CLOCK_HZ) / 1000)
`define ACFR_INTERLOCK_CYCLES  ((`ACFR_INTERLOCK_MS) * (`ACFR_MS_CYCLES))
`define ACFR_PULSE_CYCLES      16
`endif

/* rtl/acfr_pkg.sv */
package acfr_pkg;
  typedef struct packed {
    logic        run;
    logic        ready;
    logic        stall;
    logic        dc_high_alarm;
    logic        dc_low_alarm;
    logic        heatsink_hot;
    logic        ref_lost;
    logic        speed_search;
    logic        steady;
    logic        auto_enable;
    logic        step_event;
    logic        last_step_event;
    logic        trv_acc_reached;
    logic        trv_dec_reached;
    logic        mmc_selected;
    logic        mmc_signal;
    logic        zero_speed;
    logic        torque_detect;
    logic        exchange_req;
    logic        over_150;
  } acfr_drive_status_t;
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] ref_freq;
    logic [15:0] detect_freq;
    logic [15:0] detect_band;
    logic [15:0] out_current;
    logic [15:0] load_warning_level;
  } acfr_measure_t;
  typedef struct packed {
    logic        low_voltage_trip;
    logic        other_fault;
    logic        output_disable;
    logic        retry_fault;
    logic [7:0]  retry_count;
  } acfr_fault_t;
endpackage : acfr_pkg

/* rtl/acfr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// persistence timer: done after cond held limit ticks
// ****************************************
module acfr_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // control
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  // result
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         done;
  } acfr_timer_state_t;
  acfr_timer_state_t state;
  acfr_timer_state_t next_state;
  always_comb begin
    next_state = state;
    if (!cond) begin
      next_state.count = '0;
      next_state.done  = 1'b0;
    end else if (state.count >= limit) begin
      next_state.done = 1'b1;
    end else if (tick) begin
      next_state.count = state.count + 1'b1;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign done = state.done;
endmodule : acfr_timer
`default_nettype wire

/* rtl/acfr_exchange.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// line exchange with interlock gap
// ****************************************
module acfr_exchange #(
  parameter int GAP_CYCLES = 2000000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // request: 1 selects mains line
  input  wire logic to_mains,
  // line outputs
  output logic      drive_line,
  output logic      mains_line_select
);
  typedef enum logic [2:0] {
    ST_DRIVE = 3'b001,
    ST_GAP   = 3'b010,
    ST_MAINS = 3'b100
  } acfr_xchg_t;
  typedef struct packed {
    acfr_xchg_t  st;
    logic        target;
    logic [31:0] count;
  } acfr_xchg_state_t;
  acfr_xchg_state_t state;
  acfr_xchg_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state.st)
      ST_DRIVE: begin
        if (to_mains) begin
          next_state.st     = ST_GAP;
          next_state.target = 1'b1;
          next_state.count  = '0;
        end
      end
      ST_MAINS: begin
        if (!to_mains) begin
          next_state.st     = ST_GAP;
          next_state.target = 1'b0;
          next_state.count  = '0;
        end
      end
      ST_GAP: begin
        if (state.count >= 32'(GAP_CYCLES - 1)) begin
          next_state.st = state.target ? ST_MAINS : ST_DRIVE;
        end else begin
          next_state.count = state.count + 32'h1;
        end
      end
      default: begin
        next_state.st = ST_GAP;
      end
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{st: ST_DRIVE, target: 1'b0, count: 32'h0};
    end else begin
      state <= next_state;
    end
  end
  assign drive_line        = (state.st == ST_DRIVE);
  assign mains_line_select = (state.st == ST_MAINS);
endmodule : acfr_exchange
`default_nettype wire

/* rtl/acfr_top.sv */
`include "acfr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acfr_top #(
  parameter int MS_CYCLES    = `ACFR_MS_CYCLES,
  parameter int LOAD_36S_MS  = `ACFR_LOAD_36S_MS,
  parameter int LOAD_TRIP_MS = `ACFR_LOAD_TRIP_MS,
  parameter int GAP_CYCLES   = `ACFR_INTERLOCK_CYCLES,
  parameter int PULSE_CYCLES = `ACFR_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // drive state
  input  wire acfr_pkg::acfr_drive_status_t drive_status,
  input  wire acfr_pkg::acfr_measure_t     measure,
  input  wire acfr_pkg::acfr_fault_t       fault,
  input  wire logic [15:0]                 load_warning_time,
  // contacts
  output logic                             aux_contact,
  output logic                             fault_relay,
  output logic                             drive_overload,
  output logic                             drive_line
);
  import acfr_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic in_band(input logic [15:0] f, input logic [15:0] c,
                                   input logic [15:0] bw);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = {1'b0, c} - {2'b00, bw[15:1]};
    hi = {1'b0, c} + {2'b00, bw[15:1]};
    if (lo[16]) begin
      lo = 17'h0;
    end
    in_band = ({1'b0, f} >= lo) && ({1'b0, f} <= hi);
  endfunction : in_band

  function automatic logic below_band(input logic [15:0] f, input logic [15:0] c,
                                      input logic [15:0] bw);
    logic [16:0] lo;
    lo = {1'b0, c} - {2'b00, bw[15:1]};
    below_band = !lo[16] && ({1'b0, f} < lo);
  endfunction : below_band

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [4:0]  select;
    logic [2:0]  relay_cfg;
    logic        hyst;
    logic        trip;
    logic [15:0] ms_count;
    logic        ms_tick;
    logic [15:0] pulse_count;
    logic        aux_contact;
    logic        fault_relay;
    logic        drive_line;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acfr_state_t;
  acfr_state_t state;
  acfr_state_t next_state;

  logic       warn_done;
  logic       over36_done;
  logic       trip_done;
  logic       xchg_drive;
  logic       xchg_mains;
  logic       access;
  logic       cond;
  logic [4:0] eff_select;
  logic [31:0] status_word;

  // ****************************************
  // timers and exchange
  // ****************************************
  acfr_timer #(.W(16)) u_warn (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (state.ms_tick),
    .cond    (measure.out_current >= measure.load_warning_level),
    .limit   (load_warning_time),
    .done    (warn_done)
  );

  acfr_timer #(.W(32)) u_over36 (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (state.ms_tick),
    .cond    (drive_status.over_150),
    .limit   (32'(LOAD_36S_MS)),
    .done    (over36_done)
  );

  acfr_timer #(.W(32)) u_trip (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (state.ms_tick),
    .cond    (drive_status.over_150),
    .limit   (32'(LOAD_TRIP_MS)),
    .done    (trip_done)
  );

  acfr_exchange #(.GAP_CYCLES(GAP_CYCLES)) u_xchg (
    .clock             (clock),
    .reset_n           (reset_n),
    .to_mains          (drive_status.exchange_req),
    .drive_line        (xchg_drive),
    .mains_line_select (xchg_mains)
  );

  assign access      = psel && penable && !state.pready;
  assign eff_select  = drive_status.mmc_selected ? `ACFR_SEL_MMC : state.select;

  // ****************************************
  // condition mux
  // ****************************************
  always_comb begin
    cond = 1'b0;
    unique case (eff_select)
      5'h00: cond = measure.out_freq >= measure.ref_freq;
      5'h01: cond = in_band(measure.ref_freq, measure.detect_freq, measure.detect_band)
                 && in_band(measure.out_freq, measure.detect_freq,
                            measure.detect_band);
      5'h02: cond = in_band(measure.out_freq, measure.detect_freq,
                            measure.detect_band);
      5'h03: cond = state.hyst;
      5'h04: cond = !state.hyst;
      5'h05: cond = warn_done;
      5'h06: cond = over36_done;
      5'h07: cond = drive_status.stall;
      5'h08: cond = drive_status.dc_high_alarm;
      5'h09: cond = drive_status.dc_low_alarm;
      5'h0a: cond = drive_status.heatsink_hot;
      5'h0b: cond = drive_status.ref_lost;
      5'h0c: cond = drive_status.run;
      5'h0d: cond = !drive_status.run;
      5'h0e: cond = drive_status.steady;
      5'h0f: cond = xchg_drive;
      5'h10: cond = xchg_mains;
      5'h11: cond = drive_status.speed_search;
      5'h12: cond = state.pulse_count != 16'h0;
      5'h13: cond = state.pulse_count != 16'h0;
      5'h14: cond = drive_status.ready;
      5'h15: cond = drive_status.trv_acc_reached;
      5'h16: cond = drive_status.trv_dec_reached;
      5'h17: cond = drive_status.mmc_signal;
      5'h18: cond = drive_status.zero_speed;
      5'h19: cond = drive_status.torque_detect;
      default: cond = 1'b0;
    endcase
  end

  always_comb begin
    status_word = 32'h0;
    status_word[`ACFR_STATUS_AUX_BIT] = state.aux_contact;
    status_word[4] = state.fault_relay;
    status_word[5] = state.trip;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.ms_tick = 1'b0;
    if (state.ms_count >= 16'(MS_CYCLES - 1)) begin
      next_state.ms_count = 16'h0;
      next_state.ms_tick  = 1'b1;
    end else begin
      next_state.ms_count = state.ms_count + 16'h1;
    end
    if (measure.out_freq >= measure.detect_freq) begin
      next_state.hyst = 1'b1;
    end else if (below_band(measure.out_freq, measure.detect_freq, measure.detect_band)) begin
      next_state.hyst = 1'b0;
    end
    if (state.pulse_count != 16'h0) begin
      next_state.pulse_count = state.pulse_count - 16'h1;
    end
    if (drive_status.auto_enable
        && ((eff_select == 5'h12 && drive_status.step_event)
         || (eff_select == 5'h13 && drive_status.last_step_event))) begin
      next_state.pulse_count = 16'(PULSE_CYCLES);
    end
    next_state.aux_contact = cond;
    next_state.drive_line  = xchg_drive;
    if (access) begin
      next_state.pready = 1'b1;
      next_state.prdata = 32'h0;
      unique case (paddr)
        `ACFR_OFF_SELECT: begin
          if (pwrite) begin
            next_state.select = pwdata[4:0];
          end
          next_state.prdata = {27'h0, state.select};
        end
        `ACFR_OFF_RELAY_CFG: begin
          if (pwrite) begin
            next_state.relay_cfg = pwdata[2:0];
          end
          next_state.prdata = {29'h0, state.relay_cfg};
        end
        `ACFR_OFF_STATUS: begin
          next_state.prdata = status_word;
        end
        `ACFR_OFF_TRIP_CLR: begin
          if (pwrite && pwdata[0]) begin
            next_state.trip = 1'b0;
          end
        end
        default: begin
          next_state.pslverr = 1'b1;
        end
      endcase
    end
    if (trip_done) begin
      next_state.trip = 1'b1;
    end
    if (fault.low_voltage_trip) begin
      next_state.fault_relay = state.relay_cfg[`ACFR_BIT_LV];
    end else begin
      next_state.fault_relay =
          (state.relay_cfg[`ACFR_BIT_TRIP] && !fault.output_disable
           && (fault.other_fault || state.trip))
       || (state.relay_cfg[`ACFR_BIT_RETRY] && fault.retry_fault
           && fault.retry_count == 8'h0);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state           <= '0;
      state.select    <= `ACFR_SELECT_RESET;
      state.relay_cfg <= `ACFR_RELAY_CFG_RESET;
      state.drive_line <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign prdata         = state.prdata;
  assign pready         = state.pready;
  assign pslverr        = state.pslverr;
  assign aux_contact    = state.aux_contact;
  assign fault_relay    = state.fault_relay;
  assign drive_overload = state.trip;
  assign drive_line     = state.drive_line;
endmodule : acfr_top
`default_nettype wire

/* test/acfr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module acfr_properties #(
  parameter int PULSE_CYCLES = 4,
  parameter int GAP_CYCLES   = 20
) (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         reset_n,
  // apb
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // drive state
  input wire acfr_pkg::acfr_drive_status_t drive_status,
  input wire acfr_pkg::acfr_fault_t        fault,
  // contacts
  input wire logic                         aux_contact,
  input wire logic                         fault_relay,
  input wire logic                         drive_overload,
  input wire logic                         drive_line
);
  import acfr_pkg::*;
  logic [4:0] sel_q;
  logic [2:0] cfg_q;
  int         hi_q;
  int         lo_q;
  logic       wr;
  logic [4:0] code;
  assign wr = psel && penable && !pready && pwrite;
  assign code = drive_status.mmc_selected ? 5'h17 : sel_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 5'h0c;
      cfg_q <= 3'h2;
      hi_q  <= 0;
      lo_q  <= 0;
    end else begin
      if (wr && paddr == 12'h000) sel_q <= pwdata[4:0];
      if (wr && paddr == 12'h004) cfg_q <= pwdata[2:0];
      hi_q <= aux_contact ? hi_q + 1 : 0;
      lo_q <= drive_line ? 0 : lo_q + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_pulse_end;
    $fell(aux_contact) && (code == 5'h12 || code == 5'h13);
  endsequence
  apb_answer_a: assert property (s_take |=> pready) else $error("no answer");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  unmapped_err_a: assert property (s_take |=> pslverr == ($past(paddr) > 12'h00c))
    else $error("bad pslverr");
  aux_run_a: assert property (code == 5'h0c |=> aux_contact == $past(drive_status.run))
    else $error("run contact");
  aux_stop_a: assert property (code == 5'h0d |=> aux_contact == !$past(drive_status.run))
    else $error("stop contact");
  aux_reserved_a: assert property (code > 5'h19 |=> !aux_contact)
    else $error("reserved contact");
  aux_mmc_a: assert property (drive_status.mmc_selected |=> aux_contact == $past(drive_status.mmc_signal))
    else $error("mmc contact");
  pulse_width_a: assert property (s_pulse_end |-> hi_q == PULSE_CYCLES)
    else $error("pulse width");
  relay_lv_a: assert property (fault.low_voltage_trip |=> fault_relay == $past(cfg_q[0]))
    else $error("lv relay");
  exch_gap_a: assert property ($rose(drive_line) |-> lo_q >= GAP_CYCLES)
    else $error("gap short");
  trip_cause_a: assert property ($rose(drive_overload) |-> $past(drive_status.over_150))
    else $error("trip cause");
endmodule : acfr_properties
bind acfr_top acfr_properties #(.PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES))
  i_acfr_properties (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .drive_status(drive_status), .fault(fault), .aux_contact(aux_contact),
  .fault_relay(fault_relay), .drive_overload(drive_overload), .drive_line(drive_line));
`default_nettype wire

/* test/acfr_equip.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// relay-driven equipment
// ****************
module acfr_equip (
  // clock
  input  wire logic clock,
  // contacts
  input  wire logic aux_contact,
  input  wire logic drive_line,
  input  wire logic watch,
  // observations
  output int        aux_closures,
  output logic      lines_overlap
);
  logic aux_q;
  initial begin
    aux_q = 1'b0;
    aux_closures = 0;
    lines_overlap = 1'b0;
  end
  always @(posedge clock) begin
    if (aux_contact && !aux_q) aux_closures <= aux_closures + 1;
    if (watch && aux_contact && drive_line) lines_overlap <= 1'b1;
    aux_q <= aux_contact;
  end
endmodule : acfr_equip
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acfr_pkg::*;
  logic               clock;
  logic               reset_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  acfr_drive_status_t ds;
  acfr_measure_t      meas;
  acfr_fault_t        flt;
  logic [15:0]        lwt;
  logic               aux_contact;
  logic               fault_relay;
  logic               drive_overload;
  logic               drive_line;
  int                 aux_closures;
  logic               lines_overlap;
  logic               watch;
  int                 fail_count;
  int                 num_checks;
  int                 cyc = 0;
  int                 base;
  logic [31:0]        rd;
  logic               err;
  logic [4:0]  lv_code [13] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h11,
                                5'h14, 5'h15, 5'h16, 5'h18, 5'h19};
  int          lv_bit  [13] = '{17, 16, 15, 14, 13, 19, 11, 12, 18, 7, 6, 3, 2};
  logic [37:0] ft [12] = '{{5'h0, 16'd500, 16'd500, 1'b1}, {5'h0, 16'd400, 16'd500, 1'b0},
    {5'h1, 16'd1050, 16'd1000, 1'b1}, {5'h1, 16'd1050, 16'd1200, 1'b0},
    {5'h2, 16'd1050, 16'd1200, 1'b1}, {5'h2, 16'd1200, 16'd1000, 1'b0},
    {5'h3, 16'd800, 16'd1000, 1'b0}, {5'h3, 16'd1000, 16'd1000, 1'b1},
    {5'h3, 16'd950, 16'd1000, 1'b1}, {5'h3, 16'd850, 16'd1000, 1'b0},
    {5'h4, 16'd850, 16'd1000, 1'b1}, {5'h4, 16'd1000, 16'd1000, 1'b0}};
  logic [14:0] rt [8] = '{{3'h1, 4'b1100, 8'h00}, {3'h2, 4'b1100, 8'h00},
    {3'h2, 4'b0100, 8'h00}, {3'h2, 4'b0110, 8'h00}, {3'h0, 4'b0100, 8'h00},
    {3'h4, 4'b0001, 8'h00}, {3'h4, 4'b0001, 8'h01}, {3'h3, 4'b0001, 8'h00}};
  acfr_top #(.MS_CYCLES(10), .LOAD_36S_MS(36), .LOAD_TRIP_MS(60), .GAP_CYCLES(20),
    .PULSE_CYCLES(4)) i_acfr_top (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_status(ds), .measure(meas), .fault(flt),
    .load_warning_time(lwt), .aux_contact(aux_contact), .fault_relay(fault_relay),
    .drive_overload(drive_overload), .drive_line(drive_line));
  acfr_equip i_acfr_equip (.clock(clock), .aux_contact(aux_contact),
    .drive_line(drive_line), .watch(watch), .aux_closures(aux_closures),
    .lines_overlap(lines_overlap));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  task automatic exp_aux(input logic e);
    wait_cyc(3);
    check(aux_contact, e);
  endtask : exp_aux
  function automatic logic relay_exp(input logic [2:0] c, input acfr_fault_t f);
    if (f.low_voltage_trip) return c[0];
    return (c[1] && f.other_fault && !f.output_disable)
      || (c[2] && f.retry_fault && f.retry_count == 8'h00);
  endfunction : relay_exp
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ds = '0;
    meas = {32'h0, 16'd1000, 16'd200, 32'h0};
    flt = '0;
    lwt = 16'h0;
    watch = 1'b0;
    fail_count = 0;
    num_checks = 0;
    wait_cyc(3);
    reset_n <= 1'b1;
    // ****************
    // registers
    // ****************
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000000c);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00000002);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 12'h004, 32'h7);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00000007);
    ds.run <= 1'b1;
    exp_aux(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd[3], 1'b1);
    ds <= '0;
    // ****************
    // selection codes
    // ****************
    foreach (lv_code[i]) begin
      apb(1'b1, 12'h000, {27'h0, lv_code[i]});
      ds[lv_bit[i]] <= 1'b1;
      exp_aux(1'b1);
      ds[lv_bit[i]] <= 1'b0;
      exp_aux(1'b0);
    end
    apb(1'b1, 12'h000, 32'hd);
    exp_aux(1'b1);
    ds <= 20'hfffdc;
    for (int c = 26; c < 32; c++) begin
      apb(1'b1, 12'h000, c);
      exp_aux(1'b0);
    end
    ds <= '0;
    foreach (ft[i]) begin
      apb(1'b1, 12'h000, {27'h0, ft[i][37:33]});
      meas.out_freq <= ft[i][32:17];
      meas.ref_freq <= ft[i][16:1];
      exp_aux(ft[i][0]);
    end
    meas.load_warning_level <= 16'd500;
    lwt <= 16'd3;
    apb(1'b1, 12'h000, 32'h5);
    meas.out_current <= 16'd600;
    wait_cyc(20);
    check(aux_contact, 1'b0);
    wait_cyc(30);
    check(aux_contact, 1'b1);
    // ****************
    // overload trip
    // ****************
    apb(1'b1, 12'h000, 32'h6);
    ds.over_150 <= 1'b1;
    wait_cyc(300);
    check(aux_contact, 1'b0);
    wait_cyc(100);
    check(aux_contact, 1'b1);
    check(drive_overload, 1'b0);
    wait_cyc(250);
    check(drive_overload, 1'b1);
    check(fault_relay, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd[5], 1'b1);
    ds.over_150 <= 1'b0;
    apb(1'b1, 12'h00c, 32'h1);
    wait_cyc(2);
    check(drive_overload, 1'b0);
    // ****************
    // fault relay
    // ****************
    foreach (rt[i]) begin
      apb(1'b1, 12'h004, {29'h0, rt[i][14:12]});
      flt <= rt[i][11:0];
      wait_cyc(3);
      check(fault_relay, relay_exp(rt[i][14:12], rt[i][11:0]));
    end
    flt <= '0;
    // ****************
    // pulses, exchange, mmc
    // ****************
    for (int c = 18; c < 20; c++) begin
      apb(1'b1, 12'h000, c);
      for (int k = 0; k < 3; k++) begin
        ds.auto_enable <= (k != 2);
        base = aux_closures;
        ds[9:8] <= (k == 1) ? 2'b11 : 2'b10;
        @(posedge clock);
        ds[9:8] <= 2'b00;
        wait_cyc(12);
        check(aux_closures - base, (k != 2) && (c == 18 || k == 1));
      end
    end
    apb(1'b1, 12'h000, 32'h10);
    watch <= 1'b1;
    ds.exchange_req <= 1'b1;
    wait_cyc(6);
    check({drive_line, aux_contact}, 2'b00);
    wait_cyc(25);
    check({drive_line, aux_contact}, 2'b01);
    watch <= 1'b0;
    apb(1'b1, 12'h000, 32'hf);
    ds.exchange_req <= 1'b0;
    wait_cyc(6);
    check({drive_line, aux_contact}, 2'b00);
    wait_cyc(25);
    check({drive_line, aux_contact}, 2'b11);
    check(lines_overlap, 1'b0);
    apb(1'b1, 12'h000, 32'hc);
    ds.mmc_selected <= 1'b1;
    ds.mmc_signal <= 1'b1;
    exp_aux(1'b1);
    ds.mmc_signal <= 1'b0;
    exp_aux(1'b0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
